// file: rit_top.sv
// remote inhibit control and trigger output, with apb register access
// Behaviour
// - active inhibit overrides panel/host output state
// - default polarity: low or closure inhibits
// - inhibit zeroes voltage, opens output relay
// - selectable polarity; high/open inhibits when chosen
// - latching mode holds shutdown after input clears
// - protection-clear command once the input has cleared, or a change out of latching mode, leaves latched shutdown
// - live mode follows input, no latching
// - off mode ignores inhibit input entirely
// - mode kept in non-volatile store
// - no stored mode or factory: live
// - trigger pulse low for 500 us
//
// The address map and the APB slave port were left to the implementer.
`default_nettype none
module rit_top #(
  parameter int unsigned TRIGGER_PULSE_OUTPUT_CYCLES = rit_pkg::RIT_TRIGGER_PULSE_OUTPUT_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic inhibit_pin_in,
  input wire logic nv_valid_in,
  input wire logic [1:0] nv_mode_in,
  output logic [1:0] nv_mode_out,
  output logic nv_write_out,
  input wire logic volt_change_in,
  input wire logic freq_change_in,
  input wire logic list_step_in,
  input wire logic list_step_trigger_pulse_output_in,
  output logic output_enable_out,
  output logic volt_zero_out,
  output logic relay_close_out,
  output logic trigger_pulse_output_n_out
);
  import rit_pkg::*;

  logic pin_meta_q;
  logic pin_sync_q;
  rit_mode_t inhibit_mode_command_q;
  logic inhibit_polarity_command_q;
  logic trigger_pulse_output_src_q;
  logic host_on_q;
  logic latched_shutdown_mode_q;
  logic restored_q;
  logic inhibit_act;
  logic shutdown;
  logic fire;
  logic trigger_pulse_output_busy;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic clr_cmd;
  logic fact_cmd;
  logic [31:0] rd_d;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= inhibit_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // apb decode: zero wait states
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !pwrite_in;
  assign addr_ok = (paddr_in == RIT_CTRL_ADDR) || (paddr_in == RIT_CMD_ADDR) ||
                   (paddr_in == RIT_STAT_ADDR) || (paddr_in == RIT_NV_ADDR);
  assign clr_cmd = wr_en && paddr_in == RIT_CMD_ADDR && pwdata_in[RIT_CMD_CLR_BIT];
  assign fact_cmd = wr_en && paddr_in == RIT_CMD_ADDR && pwdata_in[RIT_CMD_FACT_BIT];

  assign inhibit_act = inhibit_polarity_command_q ? pin_sync_q : !pin_sync_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      restored_q <= 1'b0;
    end else begin
      restored_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      inhibit_mode_command_q <= RIT_MODE_RESET;
      inhibit_polarity_command_q <= RIT_POL_RESET;
      trigger_pulse_output_src_q <= RIT_SRC_FUNC;
      host_on_q <= 1'b0;
    end else if (fact_cmd) begin
      inhibit_mode_command_q <= RIT_MODE_RESET;
      inhibit_polarity_command_q <= RIT_POL_RESET;
      trigger_pulse_output_src_q <= RIT_SRC_FUNC;
    end else if (wr_en && paddr_in == RIT_CTRL_ADDR) begin
      // illegal mode code falls back to live
      if (pwdata_in[RIT_CTRL_MODE_LSB +: 2] == RIT_MODE_OFF ||
          pwdata_in[RIT_CTRL_MODE_LSB +: 2] == RIT_MODE_LATCH) begin
        inhibit_mode_command_q <= rit_mode_t'(pwdata_in[RIT_CTRL_MODE_LSB +: 2]);
      end else begin
        inhibit_mode_command_q <= RIT_MODE_LIVE;
      end
      inhibit_polarity_command_q <= pwdata_in[RIT_CTRL_POL_BIT];
      trigger_pulse_output_src_q <= pwdata_in[RIT_CTRL_SRC_BIT];
      host_on_q <= pwdata_in[RIT_CTRL_ON_BIT];
    end else if (!restored_q) begin
      if (nv_valid_in && (nv_mode_in == RIT_MODE_OFF || nv_mode_in == RIT_MODE_LATCH)) begin
        inhibit_mode_command_q <= rit_mode_t'(nv_mode_in);
      end else begin
        inhibit_mode_command_q <= RIT_MODE_LIVE;
      end
    end
  end

  // write mode back to store on change
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      nv_mode_out <= RIT_MODE_RESET;
      nv_write_out <= 1'b0;
    end else begin
      nv_mode_out <= inhibit_mode_command_q;
      nv_write_out <= restored_q && (nv_mode_out != inhibit_mode_command_q);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      latched_shutdown_mode_q <= 1'b0;
    end else if (inhibit_mode_command_q == RIT_MODE_LATCH && inhibit_act) begin
      latched_shutdown_mode_q <= 1'b1;
    end else if (clr_cmd || inhibit_mode_command_q != RIT_MODE_LATCH) begin
      latched_shutdown_mode_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (inhibit_mode_command_q)
      RIT_MODE_LIVE: shutdown = inhibit_act;
      RIT_MODE_LATCH: shutdown = latched_shutdown_mode_q || inhibit_act;
      RIT_MODE_OFF: shutdown = 1'b0;
      default: shutdown = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      output_enable_out <= 1'b0;
      volt_zero_out <= 1'b1;
      relay_close_out <= 1'b0;
    end else begin
      output_enable_out <= host_on_q && !shutdown;
      volt_zero_out <= shutdown || !host_on_q;
      relay_close_out <= host_on_q && !shutdown;
    end
  end

  always_comb begin
    if (trigger_pulse_output_src_q == RIT_SRC_LIST) begin
      fire = list_step_in && list_step_trigger_pulse_output_in;
    end else begin
      fire = volt_change_in || freq_change_in ||
             (wr_en && paddr_in == RIT_CMD_ADDR && pwdata_in[RIT_CMD_FUNC_BIT]);
    end
    if (wr_en && paddr_in == RIT_CMD_ADDR && pwdata_in[RIT_CMD_LIST_BIT] &&
        trigger_pulse_output_src_q == RIT_SRC_LIST) begin
      fire = 1'b1;
    end
  end

  rit_pulse #(
    .CYCLES(TRIGGER_PULSE_OUTPUT_CYCLES),
    .CNT_W(RIT_CNT_W)
  ) u_pulse (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .fire_in(fire),
    .pulse_n_out(trigger_pulse_output_n_out),
    .busy_out(trigger_pulse_output_busy)
  );

  always_comb begin
    rd_d = '0;
    if (paddr_in == RIT_CTRL_ADDR) begin
      rd_d[RIT_CTRL_MODE_LSB +: 2] = inhibit_mode_command_q;
      rd_d[RIT_CTRL_POL_BIT] = inhibit_polarity_command_q;
      rd_d[RIT_CTRL_SRC_BIT] = trigger_pulse_output_src_q;
      rd_d[RIT_CTRL_ON_BIT] = host_on_q;
    end else if (paddr_in == RIT_STAT_ADDR) begin
      rd_d[RIT_STAT_PIN_BIT] = pin_sync_q;
      rd_d[RIT_STAT_ACT_BIT] = inhibit_act;
      rd_d[RIT_STAT_LATCH_BIT] = latched_shutdown_mode_q;
      rd_d[RIT_STAT_OUT_BIT] = output_enable_out;
      rd_d[RIT_STAT_RELAY_BIT] = relay_close_out;
      rd_d[RIT_STAT_TRIGGER_PULSE_OUTPUT_BIT] = trigger_pulse_output_busy;
    end else if (paddr_in == RIT_NV_ADDR) begin
      rd_d[1:0] = nv_mode_out;
    end
  end

  // registered read data and zero-wait-state ready
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_out <= '0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !addr_ok;
      if (rd_en && !penable_in) begin
        prdata_out <= rd_d;
      end
    end
  end
endmodule : rit_top
`default_nettype wire

// file: rit_pkg.sv
// package: register map and constants for the remote inhibit and trigger block
`default_nettype none
package rit_pkg;
  localparam int unsigned RIT_CLK_HZ = 25000000;
  localparam int unsigned RIT_TRIGGER_PULSE_OUTPUT_PULSE_US = 500;
  localparam int unsigned RIT_TRIGGER_PULSE_OUTPUT_CYCLES = (RIT_CLK_HZ / 1000000) * RIT_TRIGGER_PULSE_OUTPUT_PULSE_US;
  localparam int unsigned RIT_CNT_W = 14;
  // register byte addresses
  localparam logic [11:0] RIT_CTRL_ADDR = 12'h000;
  localparam logic [11:0] RIT_CMD_ADDR = 12'h004;
  localparam logic [11:0] RIT_STAT_ADDR = 12'h008;
  localparam logic [11:0] RIT_NV_ADDR = 12'h00c;
  // control fields
  localparam int unsigned RIT_CTRL_MODE_LSB = 0;
  localparam int unsigned RIT_CTRL_POL_BIT = 2;
  localparam int unsigned RIT_CTRL_SRC_BIT = 3;
  localparam int unsigned RIT_CTRL_ON_BIT = 4;
  // command strobes
  localparam int unsigned RIT_CMD_CLR_BIT = 0;
  localparam int unsigned RIT_CMD_FUNC_BIT = 1;
  localparam int unsigned RIT_CMD_LIST_BIT = 2;
  localparam int unsigned RIT_CMD_FACT_BIT = 3;
  // status fields
  localparam int unsigned RIT_STAT_PIN_BIT = 0;
  localparam int unsigned RIT_STAT_ACT_BIT = 1;
  localparam int unsigned RIT_STAT_LATCH_BIT = 2;
  localparam int unsigned RIT_STAT_OUT_BIT = 3;
  localparam int unsigned RIT_STAT_RELAY_BIT = 4;
  localparam int unsigned RIT_STAT_TRIGGER_PULSE_OUTPUT_BIT = 5;
  typedef enum logic [1:0] {
    RIT_MODE_OFF = 2'h0,
    RIT_MODE_LIVE = 2'h1,
    RIT_MODE_LATCH = 2'h2
  } rit_mode_t;
  localparam rit_mode_t RIT_MODE_RESET = RIT_MODE_LIVE;
  localparam logic RIT_POL_RESET = 1'b0;
  localparam logic RIT_SRC_FUNC = 1'b0;
  localparam logic RIT_SRC_LIST = 1'b1;
endpackage : rit_pkg
`default_nettype wire

// file: rit_pulse.sv
// active-low pulse stretcher for the trigger output
`default_nettype none
module rit_pulse #(
  parameter int unsigned CYCLES = rit_pkg::RIT_TRIGGER_PULSE_OUTPUT_CYCLES,
  parameter int unsigned CNT_W = rit_pkg::RIT_CNT_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic fire_in,
  output logic pulse_n_out,
  output logic busy_out
);
  import rit_pkg::*;
  logic [CNT_W-1:0] cnt_q;
  // elaboration check: the counter must hold the pulse length
  if (CYCLES < 1 || CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
    $error("rit_pulse: CYCLES does not fit counter");
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else if (fire_in) begin
      cnt_q <= CNT_W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pulse_n_out <= 1'b1;
      busy_out <= 1'b0;
    end else begin
      pulse_n_out <= !(fire_in || cnt_q > CNT_W'(1));
      busy_out <= fire_in || cnt_q > CNT_W'(1);
    end
  end
endmodule : rit_pulse
`default_nettype wire

// file: rit_assertions.sv
// checker: port-level assertions for rit_top
`default_nettype none
module rit_chk #(
  parameter int unsigned TRIGGER_PULSE_OUTPUT_CYCLES = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic inhibit_pin_in,
  input wire logic [1:0] nv_mode_out,
  input wire logic volt_change_in,
  input wire logic list_step_in,
  input wire logic list_step_trigger_pulse_output_in,
  input wire logic output_enable_out,
  input wire logic relay_close_out,
  input wire logic trigger_pulse_output_n_out
);
  import rit_pkg::*;
  logic s1_q, s2_q, pol_q, src_q, act, wr;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  assign wr = psel_in && penable_in && pwrite_in && pready_out;
  assign act = !(s2_q ^ pol_q);
  // shadow sync, resets high like the pin
  always_ff @(posedge clk_sys_in) begin
    s1_q <= rst_in | inhibit_pin_in;
    s2_q <= rst_in | s1_q;
  end
  // shadow of polarity and source, factory clears both
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || (wr && paddr_in == RIT_CMD_ADDR && pwdata_in[RIT_CMD_FACT_BIT])) begin
      pol_q <= 1'b0;
      src_q <= 1'b0;
    end else if (wr && paddr_in == RIT_CTRL_ADDR) begin
      pol_q <= pwdata_in[RIT_CTRL_POL_BIT];
      src_q <= pwdata_in[RIT_CTRL_SRC_BIT];
    end
  end
  sequence s_fire;
    !src_q && volt_change_in;
  endsequence
  a_ready_next: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access cycle");
  // mode port lags the mode by one cycle, so it is read where the output lands
  a_live_off: assert property (act |=> nv_mode_out != 2'h1 ||
    (!output_enable_out && !relay_close_out))
    else $error("live inhibit not applied");
  a_sync_lag: assert property ($changed(inhibit_pin_in) && !psel_in |=> $stable(output_enable_out))
    else $error("output moved before sync");
  a_off_ignore: assert property ((!psel_in && nv_mode_out == 2'h0) [*3] |-> $stable(output_enable_out))
    else $error("off mode output moved");
  a_latch_hold: assert property ($rose(output_enable_out) && nv_mode_out == 2'h2 |-> $past(wr) || $past(wr, 2))
    else $error("latched output on without host");
  a_func_fire: assert property (s_fire |=> !trigger_pulse_output_n_out)
    else $error("no trigger on change");
  a_list_gate: assert property (src_q && trigger_pulse_output_n_out && !psel_in && !(list_step_in && list_step_trigger_pulse_output_in) |=> trigger_pulse_output_n_out)
    else $error("unflagged list trigger");
  // three cycles at least; small TRIGGER_PULSE_OUTPUT_CYCLES keeps it under
  a_trigger_pulse_output_width: assert property ($fell(trigger_pulse_output_n_out) |-> !trigger_pulse_output_n_out [*3])
    else $error("trigger pulse too short");
endmodule : rit_chk
bind rit_top rit_chk #(.TRIGGER_PULSE_OUTPUT_CYCLES(TRIGGER_PULSE_OUTPUT_CYCLES)) u_chk (.clk_sys_in, .rst_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .inhibit_pin_in, .nv_mode_out,
  .volt_change_in, .list_step_in, .list_step_trigger_pulse_output_in, .output_enable_out, .relay_close_out,
  .trigger_pulse_output_n_out);
`default_nettype wire

// file: rit_inhib_src.sv
// external contact on the isolated inhibit input
`default_nettype none
module rit_inhib_src (
  input wire logic closed_in,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // open contact floats to the pull-up; skew keeps edges off the clock
  initial pin_out = 1'b1;
  always @(closed_in) pin_out <= #13 !closed_in;
endmodule : rit_inhib_src
`default_nettype wire

// file: tb.sv
// self-checking testbench for rit_top
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rit_pkg::*;
  localparam int TC = 4;
  localparam logic [2:0] ON = 3'h5;
  localparam logic [2:0] OFF = 3'h2;
  logic clk_sys_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, err, inhibit_pin_in, nv_valid_in = 1'b0, closed = 1'b0;
  logic [1:0] nv_mode_in = 2'h0;
  logic volt_change_in = 1'b0, freq_change_in = 1'b0, list_step_in = 1'b0;
  logic list_step_trigger_pulse_output_in = 1'b0, output_enable_out, volt_zero_out, relay_close_out;
  logic trigger_pulse_output_n_out, nv_write_out;
  int error_cnt = 0, n_tests = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  rit_top #(.TRIGGER_PULSE_OUTPUT_CYCLES(TC)) u_dut (.clk_sys_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .inhibit_pin_in,
    .nv_valid_in, .nv_mode_in, .nv_mode_out(), .nv_write_out, .volt_change_in,
    .freq_change_in, .list_step_in, .list_step_trigger_pulse_output_in, .output_enable_out, .volt_zero_out,
    .relay_close_out, .trigger_pulse_output_n_out);
  rit_inhib_src u_src (.closed_in(closed), .pin_out(inhibit_pin_in));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task pin(input logic c, input logic [2:0] e);
    @(posedge clk_sys_in);
    closed <= c;
    cyc(6);
    chk(32'({output_enable_out, volt_zero_out, relay_close_out}), 32'(e));
  endtask : pin
  task fire(input logic [2:0] v, input logic e);
    @(posedge clk_sys_in);
    {volt_change_in, freq_change_in, list_step_in} <= v;
    @(posedge clk_sys_in);
    {volt_change_in, freq_change_in, list_step_in} <= 3'h0;
    #1;
    chk(32'(trigger_pulse_output_n_out), 32'(e));
    cyc(TC - 1);
    chk(32'(trigger_pulse_output_n_out), 32'(e));
    cyc(1);
    chk(32'(trigger_pulse_output_n_out), 32'h1);
    cyc(3);
  endtask : fire
  task t_reset;
    apb(1'b0, RIT_CTRL_ADDR, 32'h0);
    chk(rd, 32'h1);
    // illegal mode code falls back to live
    apb(1'b1, RIT_CTRL_ADDR, 32'h0);
    apb(1'b1, RIT_CTRL_ADDR, 32'h3);
    apb(1'b0, RIT_CTRL_ADDR, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, RIT_CMD_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h010, 32'h1f);
    chk(32'(err), 32'h1);
  endtask : t_reset
  task t_inhibit;
    apb(1'b1, RIT_CTRL_ADDR, 32'h11);
    pin(1'b0, ON);
    pin(1'b1, OFF);
    pin(1'b0, ON);
    apb(1'b1, RIT_CTRL_ADDR, 32'h15);
    pin(1'b0, OFF);
    pin(1'b1, ON);
    apb(1'b1, RIT_CTRL_ADDR, 32'h12);
    pin(1'b1, OFF);
    apb(1'b0, RIT_STAT_ADDR, 32'h0);
    chk(rd, 32'h6);
    // host clear while pin still active must not release
    apb(1'b1, RIT_CMD_ADDR, 32'h1);
    pin(1'b0, OFF);
    apb(1'b1, RIT_CMD_ADDR, 32'h1);
    cyc(3);
    chk(32'({output_enable_out, volt_zero_out, relay_close_out}), 32'(ON));
    apb(1'b1, RIT_CTRL_ADDR, 32'h10);
    pin(1'b1, ON);
  endtask : t_inhibit
  task t_trigger_pulse_output;
    fire(3'h4, 1'b0);
    fire(3'h2, 1'b0);
    apb(1'b1, RIT_CMD_ADDR, 32'h2);
    cyc(1);
    chk(32'(trigger_pulse_output_n_out), 32'h0);
    cyc(TC + 2);
    apb(1'b1, RIT_CTRL_ADDR, 32'h18);
    fire(3'h4, 1'b1);
    fire(3'h1, 1'b1);
    @(posedge clk_sys_in);
    list_step_trigger_pulse_output_in <= 1'b1;
    fire(3'h1, 1'b0);
    apb(1'b1, RIT_CMD_ADDR, 32'h4);
    cyc(2);
    chk(32'(trigger_pulse_output_n_out), 32'h0);
  endtask : t_trigger_pulse_output
  task t_store;
    apb(1'b1, RIT_CTRL_ADDR, 32'h2);
    nv_valid_in <= 1'b1;
    nv_mode_in <= 2'h2;
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // store port shows the restored mode one cycle after the restore
    cyc(2);
    apb(1'b0, RIT_NV_ADDR, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, RIT_CMD_ADDR, 32'h8);
    cyc(1);
    chk(32'(nv_write_out), 32'h1);
    apb(1'b0, RIT_NV_ADDR, 32'h0);
    chk(rd, 32'h1);
  endtask : t_store
  task summarize;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset;
    t_inhibit;
    t_trigger_pulse_output;
    t_store;
    summarize;
  end
  // run needs about 200 cycles; this allows many times that
  initial begin
    #200us;
    error_cnt++;
    summarize;
  end
endmodule : tb
`default_nettype wire
